// ==== rtl/kpi_pkg.sv ====
// Shared constants, register map and helpers for the keypad pin interrupt unit.
package kpi_pkg;

  // Number of watched pins and register port widths.
  localparam int KPI_NUM_PINS = 8;
  localparam int KPI_ADDR_W = 8;
  localparam int KPI_DATA_W = 32;

  // Register byte offsets.
  localparam logic [KPI_ADDR_W-1:0] KPI_OFS_CTRL = 8'h00;
  localparam logic [KPI_ADDR_W-1:0] KPI_OFS_PIN_EN = 8'h04;
  localparam logic [KPI_ADDR_W-1:0] KPI_OFS_PIN_POL = 8'h08;
  localparam logic [KPI_ADDR_W-1:0] KPI_OFS_STATUS = 8'h0C;
  localparam logic [KPI_ADDR_W-1:0] KPI_OFS_SOURCE = 8'h10;
  localparam logic [KPI_ADDR_W-1:0] KPI_OFS_INT_MASK = 8'h14;

  // Field positions inside the control, status and mask words.
  localparam int KPI_CTRL_ON_BIT = 0;
  localparam int KPI_CTRL_MODE_BIT = 1;
  localparam int KPI_STATUS_DET_BIT = 0;
  localparam int KPI_MASK_DET_BIT = 0;

  // Detection mode, one bit in the control word.
  typedef enum logic {
    edge_only_detection = 1'b0,
    edge_and_level_detection = 1'b1
  } kpi_mode_t;

  // Values after reset.
  localparam logic KPI_RST_UNIT_ON = 1'b0;
  localparam kpi_mode_t KPI_RST_MODE = edge_only_detection;
  localparam logic KPI_RST_INT_EN = 1'b0;
  localparam logic [1:0] KPI_RST_SYNC = 2'h0;

  // Per-pin match of a sampled level against the selected polarity.
  function automatic logic [KPI_DATA_W-1:0] kpi_match(input logic [KPI_DATA_W-1:0] lvl,
                                                      input logic [KPI_DATA_W-1:0] pol);
    kpi_match = ~(lvl ^ pol);
  endfunction

endpackage

// ==== rtl/kpi_pin_if.sv ====
`timescale 1ns/100ps
// Synchronised pin levels passed from the pin sampler to the detector core.
interface kpi_pin_if #(
  parameter int NUM_PINS = 8
);
  logic [NUM_PINS-1:0] level; // Current synchronised level of each pin.
  logic [NUM_PINS-1:0] prev; // Level one cycle earlier.

  modport det (output level, output prev);
  modport core (input level, input prev);
endinterface

// ==== rtl/kpi_pin_sync.sv ====
`timescale 1ns/100ps
// Two-flop synchroniser for the keypad pins plus a one-cycle history stage.
module kpi_pin_sync #(
  parameter int NUM_PINS = 8
) (
  input wire logic sys_clk_i, // System clock.
  input wire logic rst_n_i, // Synchronised reset, active low.
  input wire logic [NUM_PINS-1:0] pins_i, // Raw keypad pins.
  kpi_pin_if.det pin_bus // Sampled levels towards the core.
);
  import kpi_pkg::*;

  // All sampler state lives in one record.
  typedef struct packed {
    logic [NUM_PINS-1:0] sync1; // First stage, read only by the second.
    logic [NUM_PINS-1:0] sync2; // Second stage, safe to use.
    logic [NUM_PINS-1:0] prev; // History for edge finding.
  } kpi_sync_t;

  kpi_sync_t st_ff;
  kpi_sync_t nxt_st;

  // Shift the pins through the chain every cycle.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync1 = pins_i;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev = st_ff.sync2;
  end

  // Register the record; pins read as low until sampled.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_bus.level = st_ff.sync2;
  assign pin_bus.prev = st_ff.prev;
endmodule

// ==== rtl/kpi_top.sv ====
// Behaviour
// RULE1: Eight pins, each gated by enable bit.
// RULE2: Per-pin polarity: one rising/high, zero falling/low.
// RULE3: Edge-only mode detects selected-direction transitions only.
// RULE4: Edge-and-level mode also detects held active level.
// RULE5: Detect flag sticks until software clears it.
// RULE6: Software write clears the detect flag.
// RULE7: Readable source vector shows which pins fired.
// RULE8: Gated off: no detection, no register updates; here the control word (on bit, mode) still takes writes.
// RULE9: Interrupt needs enable and flag; disable keeps flag.
// RULE10: Level mode re-sets flag right after clear.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/100ps
module kpi_top #(
  parameter int NUM_PINS = kpi_pkg::KPI_NUM_PINS
) (
  input wire logic sys_clk_i, // System clock, 25 MHz.
  input wire logic reset_n_i, // Asynchronous reset, active low.
  input wire logic [NUM_PINS-1:0] pins_i, // Keypad pins from outside.
  input wire logic [kpi_pkg::KPI_ADDR_W-1:0] addr_i, // Register byte address.
  input wire logic [kpi_pkg::KPI_DATA_W-1:0] wdata_i, // Register write data.
  input wire logic wr_i, // Write strobe, one cycle.
  input wire logic rd_i, // Read strobe, one cycle.
  output logic [kpi_pkg::KPI_DATA_W-1:0] rdata_o, // Read data, cycle after rd_i.
  output logic irq_o // Interrupt request, level, active high.
);
  import kpi_pkg::*;

  // Refuse pin counts that do not fit one register word.
  if (NUM_PINS < 1 || NUM_PINS > KPI_DATA_W) begin : g_bad_pins
    $error("NUM_PINS must lie between 1 and the data width.");
  end

  // All core state lives in one record.
  // Keeping it in one record lets a single flop process hold every register.
  typedef struct packed {
    logic unit_on; // Stands for the peripheral clock gate.
    kpi_mode_t mode; // Edge-only or edge-and-level detection.
    logic [NUM_PINS-1:0] pin_enable_mask; // Pins allowed to raise events.
    logic [NUM_PINS-1:0] pin_polarity_mask; // One: rising/high, zero: falling/low.
    logic int_en; // Interrupt mask bit for the detect flag.
    logic detect; // Sticky detect flag.
    logic [NUM_PINS-1:0] source; // Pins that fired since the last clear.
    logic [KPI_DATA_W-1:0] rdata; // Read answer, valid one cycle.
    logic irq; // Registered interrupt output.
  } kpi_state_t;

  // The registered record and its next value: one always_comb block builds the
  // next value from the detection terms and a single always_ff registers it.
  kpi_state_t st_ff; // Current state.
  kpi_state_t nxt_st; // Next state.
  // Reset release chain and the copy of reset that every other flop uses.
  logic [1:0] rst_sync_ff; // Reset release chain.
  logic rst_n; // Synchronised reset used by all other logic.
  // Per-cycle detection terms, all combinational.
  logic [NUM_PINS-1:0] match; // Pins now at their selected level.
  logic [NUM_PINS-1:0] edge_hit; // Pins that just reached their selected level.
  logic [NUM_PINS-1:0] hit; // Qualified events this cycle.
  logic clear_req; // Software asks to clear the flag.

  // Carrier for the synchronised levels between the sampler and this core.
  kpi_pin_if #(.NUM_PINS(NUM_PINS)) pin_bus ();

  // Reset asserts at once and releases two edges later, so no flop sees a
  // release that races the clock.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_ff <= KPI_RST_SYNC;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // The pins come from switches, so they cross into this clock first.
  // The sampler shares the internal reset, so its history matches the core after reset.
  kpi_pin_sync #(
    .NUM_PINS(NUM_PINS)
  ) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .pins_i(pins_i),
    .pin_bus(pin_bus)
  );

  // Event qualification from the synchronised levels.
  // A pin that toggles twice between two clock edges may be missed; keys move far
  // slower than the clock, so no pulse stretcher is spent on this.
  always_comb begin
    // RULE2: polarity level match
    match = NUM_PINS'(kpi_match(KPI_DATA_W'(pin_bus.level),
                                KPI_DATA_W'(st_ff.pin_polarity_mask)));
    edge_hit = match & ~NUM_PINS'(kpi_match(KPI_DATA_W'(pin_bus.prev),
                                            KPI_DATA_W'(st_ff.pin_polarity_mask)));
    // RULE3: edge-only transitions
    // RULE4: level also counts
    if (st_ff.mode == edge_and_level_detection) begin
      hit = match;
    end else begin
      hit = edge_hit;
    end
    // RULE1: enabled pins only
    // RULE8: no detection gated
    hit = hit & st_ff.pin_enable_mask & {NUM_PINS{st_ff.unit_on}};
    // A clear only counts while the unit runs, like every write except the control word.
    clear_req = wr_i && st_ff.unit_on && (addr_i == KPI_OFS_STATUS) &&
                wdata_i[KPI_STATUS_DET_BIT];
  end

  // Register writes, flag handling and read answers.
  always_comb begin
    nxt_st = st_ff;
    // Read data stand for one cycle only and read as zero otherwise.
    nxt_st.rdata = '0;
    if (wr_i) begin
      // RULE8: gated writes ignored
      // The control word stays writable so software can ungate the unit.
      if (addr_i == KPI_OFS_CTRL) begin
        nxt_st.unit_on = wdata_i[KPI_CTRL_ON_BIT];
        nxt_st.mode = kpi_mode_t'(wdata_i[KPI_CTRL_MODE_BIT]);
      end else if (st_ff.unit_on) begin
        case (addr_i)
          KPI_OFS_PIN_EN: begin
            nxt_st.pin_enable_mask = wdata_i[NUM_PINS-1:0];
          end
          KPI_OFS_PIN_POL: begin
            nxt_st.pin_polarity_mask = wdata_i[NUM_PINS-1:0];
          end
          KPI_OFS_INT_MASK: begin
            // RULE9: mask leaves flag
            nxt_st.int_en = wdata_i[KPI_MASK_DET_BIT];
          end
          default: begin
            // Status is handled below; other addresses are ignored.
          end
        endcase
      end
    end
    // RULE6: write-one clears
    if (clear_req) begin
      nxt_st.detect = 1'b0;
      nxt_st.source = '0;
    end
    // RULE5: sticky detect flag
    // RULE10: level re-sets flag
    // A set in the same cycle as a clear wins, so no event is lost.
    if (|hit) begin
      nxt_st.detect = 1'b1;
      // RULE7: record firing pins
      nxt_st.source = nxt_st.source | hit;
    end
    // Read answers come from the state before this edge, so a read that meets an
    // event shows the old flag; the new one is seen by the next read.
    if (rd_i) begin
      case (addr_i)
        KPI_OFS_CTRL: begin
          nxt_st.rdata[KPI_CTRL_ON_BIT] = st_ff.unit_on;
          nxt_st.rdata[KPI_CTRL_MODE_BIT] = st_ff.mode;
        end
        KPI_OFS_PIN_EN: begin
          nxt_st.rdata = KPI_DATA_W'(st_ff.pin_enable_mask);
        end
        KPI_OFS_PIN_POL: begin
          nxt_st.rdata = KPI_DATA_W'(st_ff.pin_polarity_mask);
        end
        KPI_OFS_STATUS: begin
          nxt_st.rdata[KPI_STATUS_DET_BIT] = st_ff.detect;
        end
        KPI_OFS_SOURCE: begin
          nxt_st.rdata = KPI_DATA_W'(st_ff.source);
        end
        KPI_OFS_INT_MASK: begin
          nxt_st.rdata[KPI_MASK_DET_BIT] = st_ff.int_en;
        end
        default: begin
          // Unmapped addresses answer zero.
          nxt_st.rdata = '0;
        end
      endcase
    end
    // The request is built from the next values, so irq_o moves with the flag.
    // RULE9: irq needs both
    nxt_st.irq = nxt_st.int_en & nxt_st.detect;
  end

  // Register the record; everything starts disabled and clear.
  // Only constants load in the reset branch, so the reset path stays simple.
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.unit_on <= KPI_RST_UNIT_ON;
      st_ff.mode <= KPI_RST_MODE;
      st_ff.int_en <= KPI_RST_INT_EN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Both outputs come straight from flops of the record.
  assign rdata_o = st_ff.rdata;
  assign irq_o = st_ff.irq;

  // Checks of the detector against its causes.
  // They run on the internal reset copy, so they stay quiet until logic leaves reset.
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n);

  // The interrupt follows the flag and its mask bit exactly.
  irq_follows_flag_a: assert property ( // RULE9
    irq_o == (st_ff.detect && st_ff.int_en))
    else $error("Interrupt differs from flag and mask.");

  // Masking the interrupt never clears a set flag.
  mask_keeps_flag_a: assert property ( // RULE9
    (wr_i && addr_i == KPI_OFS_INT_MASK && st_ff.detect) |=> st_ff.detect)
    else $error("Mask write disturbed the detect flag.");

  // A qualified event sets the flag on the next edge and holds it.
  event_sets_flag_a: assert property ( // RULE5
    (|hit) |=> st_ff.detect [*2] or (st_ff.detect ##1 $fell(st_ff.detect) &&
    $past(clear_req)))
    else $error("Detect flag not set or not held after an event.");

  // Edge-only mode ignores pins that merely sit at their level.
  edge_only_quiet_a: assert property ( // RULE3
    (st_ff.mode == edge_only_detection && !st_ff.detect &&
     (st_ff.pin_enable_mask & edge_hit) == '0) |=> !st_ff.detect)
    else $error("Flag set in edge-only mode without an edge.");

  // Edge-and-level mode fires while an enabled pin holds its level.
  level_fires_a: assert property ( // RULE4
    (st_ff.unit_on && st_ff.mode == edge_and_level_detection &&
     |(st_ff.pin_enable_mask & match)) |=> st_ff.detect)
    else $error("Held active level did not set the flag.");

  // Polarity one on pin zero means a high level is active.
  polarity_high_a: assert property ( // RULE2
    (st_ff.unit_on && st_ff.mode == edge_and_level_detection &&
     st_ff.pin_enable_mask[0] && st_ff.pin_polarity_mask[0] && pin_bus.level[0])
    |=> st_ff.detect && st_ff.source[0])
    else $error("High level with rising polarity not detected.");

  // A clear with no new event empties the flag and the source vector.
  clear_empties_a: assert property ( // RULE6
    (clear_req && !(|hit)) |=> !st_ff.detect && st_ff.source == '0)
    else $error("Clear left the flag or source set.");

  // Level mode re-raises the flag one cycle after a clear.
  level_reraise_a: assert property ( // RULE10
    (clear_req && st_ff.mode == edge_and_level_detection &&
     |(st_ff.pin_enable_mask & match)) |=> st_ff.detect)
    else $error("Flag not re-set while a level stays active.");

  // The source vector records every pin that fired.
  source_records_a: assert property ( // RULE7
    (|hit) |=> (st_ff.source & $past(hit)) == $past(hit))
    else $error("Source vector missed a firing pin.");

  // With no pin enabled the flag cannot rise.
  no_enable_quiet_a: assert property ( // RULE1
    (st_ff.pin_enable_mask == '0 && !st_ff.detect) |=> !st_ff.detect)
    else $error("Flag set with every pin disabled.");

  // While gated, configuration and flags stay frozen.
  gated_frozen_a: assert property ( // RULE8
    (!st_ff.unit_on && !(wr_i && addr_i == KPI_OFS_CTRL)) |=>
    $stable(st_ff.detect) && $stable(st_ff.pin_enable_mask) &&
    $stable(st_ff.int_en) && $stable(st_ff.source))
    else $error("State changed while the unit was gated.");

  // Disabled pins never add a bit to the source vector.
  disabled_no_source_a: assert property ( // RULE1
    ((st_ff.source & ~$past(st_ff.source)) & ~$past(st_ff.pin_enable_mask)) == '0)
    else $error("Source bit set for a disabled pin.");

  // Polarity zero: a falling edge on an enabled pin sets the flag.
  falling_edge_sets_a: assert property ( // RULE2
    (st_ff.unit_on &&
     |(st_ff.pin_enable_mask & ~st_ff.pin_polarity_mask & pin_bus.prev & ~pin_bus.level))
    |=> st_ff.detect)
    else $error("Falling edge with falling polarity not detected.");

  // While gated, a quiet interrupt stays quiet.
  gated_irq_quiet_a: assert property ( // RULE8
    (!st_ff.unit_on && !(wr_i && addr_i == KPI_OFS_CTRL) && !irq_o) |=> !irq_o)
    else $error("Interrupt rose while the unit was gated.");

  // A status read returns the flag held at the read edge.
  status_read_a: assert property ( // RULE5
    (rd_i && addr_i == KPI_OFS_STATUS) |=> rdata_o == KPI_DATA_W'($past(st_ff.detect)))
    else $error("Status read differs from the detect flag.");

  // A source read returns the recorded pins.
  source_read_a: assert property ( // RULE7
    (rd_i && addr_i == KPI_OFS_SOURCE) |=> rdata_o == KPI_DATA_W'($past(st_ff.source)))
    else $error("Source read differs from the recorded pins.");

  // The enable word reads back as held.
  enable_read_a: assert property ( // RULE1
    (rd_i && addr_i == KPI_OFS_PIN_EN) |=>
    rdata_o == KPI_DATA_W'($past(st_ff.pin_enable_mask)))
    else $error("Enable read differs from the held mask.");

  // The polarity word reads back as held.
  polarity_read_a: assert property ( // RULE2
    (rd_i && addr_i == KPI_OFS_PIN_POL) |=>
    rdata_o == KPI_DATA_W'($past(st_ff.pin_polarity_mask)))
    else $error("Polarity read differs from the held mask.");

  // Main scenarios worth seeing.
  edge_event_c: cover property (st_ff.mode == edge_only_detection && (|hit));
  level_reraise_c: cover property (clear_req && (|hit));
  irq_raised_c: cover property ($rose(irq_o));
  read_source_c: cover property (rd_i && addr_i == KPI_OFS_SOURCE && st_ff.detect);
  gated_write_c: cover property (!st_ff.unit_on && wr_i && addr_i != KPI_OFS_CTRL);
endmodule

// ==== bench/kpi_keys.sv ====
`timescale 1ns/100ps
// Keypad model: a key line rests at its idle level and a held key drives the opposite level.
module kpi_keys #(
  parameter int NUM_KEYS = 8
) (
  input wire logic [NUM_KEYS-1:0] idle_i, // Resting level of each line.
  input wire logic [NUM_KEYS-1:0] press_i, // Keys held down.
  output logic [NUM_KEYS-1:0] pins_o // Levels seen on the pins.
);
  // Keys change only with the bench clock, so each level lasts at least one period.
  assign pins_o = idle_i ^ press_i;
endmodule

// ==== bench/test_keypad_pin_interrupt.sv ====
`timescale 1ns/100ps
// Self-checking bench; a reference model follows the pin pipeline and registers each cycle.
module test_keypad_pin_interrupt;
  import kpi_pkg::*;
  // Reference state of the unit.
  typedef struct {int on; int mode; int en; int pol; int msk; int det; int src;
    int s1; int s2; int pv;} kpi_bm_t;
  logic sys_clk_i = 1'b0; // System clock.
  logic reset_n_i = 1'b0; // Reset, active low.
  logic [7:0] idle = 8'hFF; // Lines rest high.
  logic [7:0] press = 8'h00; // Keys held down.
  logic [7:0] pins; // Pin levels.
  logic [KPI_ADDR_W-1:0] addr_i = 8'h00; // Register address.
  logic [KPI_DATA_W-1:0] wdata_i = 32'h0; // Write data.
  logic wr_i = 1'b0; // Write strobe.
  logic rd_i = 1'b0; // Read strobe.
  logic [KPI_DATA_W-1:0] rdata_o; // Read data.
  logic irq_o; // Interrupt.
  kpi_bm_t md; // Model state.
  int rc; // Edges since reset release.
  logic [31:0] exp_rd; // Expected read data.
  int fail_count; // Mismatches.
  int checks; // Comparisons.
  int seed; // Random seed.
  int i; // Loop index.

  // Clock of 40 ns.
  always #20 sys_clk_i = ~sys_clk_i;

  kpi_keys #(.NUM_KEYS(8)) keys (.idle_i(idle), .press_i(press), .pins_o(pins));
  kpi_top #(.NUM_PINS(8)) uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .pins_i(pins),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o));

  // Register view of the model.
  function automatic logic [31:0] reg_val(input logic [7:0] a);
    case (a)
      KPI_OFS_CTRL: reg_val = 32'(md.mode * 2 + md.on);
      KPI_OFS_PIN_EN: reg_val = 32'(md.en);
      KPI_OFS_PIN_POL: reg_val = 32'(md.pol);
      KPI_OFS_STATUS: reg_val = 32'(md.det);
      KPI_OFS_SOURCE: reg_val = 32'(md.src);
      KPI_OFS_INT_MASK: reg_val = 32'(md.msk);
      default: reg_val = 32'h0;
    endcase
  endfunction

  // Model step; detection uses the state from before the edge, so a clear loses to a set.
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    int fire;
    int mt;
    int on_old;
    if (!reset_n_i) begin
      md = '{default:0};
      rc = 0;
      exp_rd = 32'h0;
    end else if (rc < 2) begin
      rc++;
    end else begin
      exp_rd = rd_i ? reg_val(addr_i) : 32'h0;
      mt = ~(md.s2 ^ md.pol) & 32'hFF;
      fire = md.en & ((mt & ~(~(md.pv ^ md.pol) & 32'hFF)) | (md.mode != 0 ? mt : 0));
      on_old = md.on;
      if (wr_i && addr_i == KPI_OFS_CTRL) begin
        md.on = wdata_i[0];
        md.mode = wdata_i[1];
      end else if (wr_i && md.on != 0) begin
        case (addr_i)
          KPI_OFS_PIN_EN: md.en = wdata_i[7:0];
          KPI_OFS_PIN_POL: md.pol = wdata_i[7:0];
          KPI_OFS_INT_MASK: md.msk = wdata_i[0];
          KPI_OFS_STATUS: if (wdata_i[0]) begin
            md.det = 0;
            md.src = 0;
          end
          default: ;
        endcase
      end
      if (on_old != 0 && fire != 0) begin
        md.det = 1;
        md.src = md.src | fire;
      end
      md.pv = md.s2;
      md.s2 = md.s1;
      md.s1 = pins;
    end
  end

  task automatic cmp_data(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_irq(input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected irq_o: expected %b, seen %b", e, g);
    end
  endtask

  // Outputs are compared mid-cycle, where they have settled.
  always @(negedge sys_clk_i) begin
    cmp_data("rdata_o", exp_rd, rdata_o);
    cmp_irq(md.det != 0 && md.msk != 0, irq_o);
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Cuts a hang short; the tests need about 1,100 cycles, so some eighteen times that is ample.
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fail_count++;
    give_verdict();
  end

  initial begin
    seed = 32'h8A80F900;
    tick(4);
    reset_n_i <= 1'b1;
    tick(3);
    for (i = 0; i <= 24; i += 4) rd_reg(8'(i));
    wr_reg(KPI_OFS_PIN_EN, 32'hFF);
    rd_reg(KPI_OFS_PIN_EN);
    wr_reg(KPI_OFS_CTRL, 32'h1);
    wr_reg(KPI_OFS_PIN_EN, 32'h0F);
    wr_reg(KPI_OFS_PIN_POL, 32'hA5);
    wr_reg(KPI_OFS_INT_MASK, 32'h1);
    // Each key pressed, held past a clear, then released.
    for (i = 0; i < 8; i++) begin
      press <= 8'h01 << i;
      tick(6);
      rd_reg(KPI_OFS_SOURCE);
      wr_reg(KPI_OFS_STATUS, 32'h1);
      tick(3);
      rd_reg(KPI_OFS_STATUS);
      press <= 8'h00;
      tick(6);
      rd_reg(KPI_OFS_SOURCE);
      wr_reg(KPI_OFS_STATUS, 32'h1);
    end
    wr_reg(KPI_OFS_CTRL, 32'h3);
    press <= 8'h02;
    tick(6);
    wr_reg(KPI_OFS_STATUS, 32'h1);
    rd_reg(KPI_OFS_STATUS);
    wr_reg(KPI_OFS_INT_MASK, 32'h0);
    rd_reg(KPI_OFS_STATUS);
    wr_reg(KPI_OFS_INT_MASK, 32'h1);
    press <= 8'h00;
    tick(4);
    wr_reg(KPI_OFS_STATUS, 32'h1);
    wr_reg(KPI_OFS_CTRL, 32'h0);
    press <= 8'hFF;
    tick(6);
    wr_reg(KPI_OFS_PIN_POL, 32'h00);
    rd_reg(KPI_OFS_STATUS);
    rd_reg(KPI_OFS_PIN_POL);
    press <= 8'h00;
    wr_reg(KPI_OFS_CTRL, 32'h1);
    // A reset in mid-run returns every register to its idle value.
    reset_n_i <= 1'b0;
    tick(2);
    reset_n_i <= 1'b1;
    tick(3);
    rd_reg(KPI_OFS_CTRL);
    rd_reg(KPI_OFS_SOURCE);
    wr_reg(KPI_OFS_CTRL, 32'h1);
    wr_reg(KPI_OFS_PIN_EN, 32'hFF);
    wr_reg(KPI_OFS_INT_MASK, 32'h1);
    // Random traffic on keys and registers.
    for (i = 0; i < 300; i++) begin
      case ($unsigned($random(seed)) % 6)
        0: press <= 8'($random(seed));
        1: wr_reg(KPI_OFS_PIN_EN + 8'(4 * ($unsigned($random(seed)) % 2)),
          32'($random(seed)) & 32'hFF);
        2: wr_reg(KPI_OFS_STATUS, 32'($random(seed)));
        3: rd_reg(8'(4 * ($unsigned($random(seed)) % 7)));
        4: wr_reg(KPI_OFS_INT_MASK, 32'($random(seed)));
        default: wr_reg(KPI_OFS_CTRL, 32'(1 + 2 * ($unsigned($random(seed)) % 2)));
      endcase
      tick(1);
    end
    tick(4);
    give_verdict();
  end
endmodule
